//--- config_memory_op_decode.sv
// Configuration memory with its address and buffer registers, and the
// three-stage op-code register pipeline with first, second and class
// decoders. Assumes cycle-counter pulses and instruction buffer fields
// arrive from logic on the same clock, and that the register port master
// follows the one-cycle strobe protocol.
//
// How it works
// - The five configuration bits are copied into the address register.
// - Address normally selects memory; during index jumps it is the increment.
// - Address register steps during multi-word configuration load and fetch.
// - Memory is 32 words of 10 bits, selected by two-stage decode.
// - A read word goes to the buffer, decoded into subword form, activity, permutation.
// - Word selection is active only while the memory select flip-flop is set.
// - A write stores the whole buffer, parity included, into the word.
// - During a write the digit-write flip-flop follows each buffer bit.
// - A read clears digit-write, pulses the word, leaving it all zero.
// - Address bit five picks the read strobe polarity of array one or two.
// - The complement-read mode stays disabled with its flip-flop held zero.
// - Op bits move from buffer to fetch, operand, then arithmetic stage.
// - Arithmetic-only operates load buffer bits straight into arithmetic stage.
// - Fetch stage loads at pulse 12 alpha; decodes valid for the cycle.
// - Operand start copies fetch stage; arithmetic ops copy onward at 13 alpha.
// - Three op registers let three instructions overlap.
// - Fetch decodes serve all cycles, operand mostly, arithmetic only arithmetic.
// - First level decodes upper and lower three bits into eight lines each.
// - Second level ANDs one line of each group, only lines needed.
// - Each op register has a class decoder for shared-property groups.
// - Fetch classes flag config use, four-word use and memory writing.
// - Operand stage never holds undefined codes; its classes ignore them.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/1ps

module config_memory_op_decode #(
	// Op codes of the configuration operations; values are arbitrary.
	parameter logic [5:0] OP_CFG_LOAD_ONE = 6'h10,
	parameter logic [5:0] OP_CFG_LOAD_MULTI = 6'h11,
	parameter logic [5:0] OP_CFG_FETCH_ONE = 6'h12,
	parameter logic [5:0] OP_CFG_FETCH_MULTI = 6'h13,
	// One bit per op code marking use of the arithmetic cycle counter.
	parameter logic [63:0] ARITH_CLASS_MAP = 64'hffff_0000_0000_0000,
	parameter int WORDS = config_op_decode_pkg::CFG_WORDS
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Instruction buffer fields.
	input wire logic [4:0] i_ib_config,
	input wire logic [5:0] i_ib_opcode,
	input wire logic [5:0] i_ib_aop_bits,
	// Cycle-counter pulses and qualifiers.
	input wire logic i_pk12,
	input wire logic i_pk25,
	input wire logic i_qk_start,
	input wire logic i_qk13,
	input wire logic i_arith_only,
	input wire logic i_index_jump,
	input wire logic i_cfg_start,
	// Register port.
	input wire logic [1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Configuration results.
	output logic [4:0] o_index_increment,
	output logic [1:0] o_subword_form,
	output logic [3:0] o_activity,
	output logic [2:0] o_permutation,
	output logic o_parity_error,
	output logic o_word_valid,
	output logic o_cfg_busy,
	output logic o_cfg_done,
	output logic o_memory_select,
	output logic [9:0] o_digit_write,
	// Op decode levels.
	output logic [7:0] o_fetch_hi,
	output logic [7:0] o_fetch_lo,
	output logic [7:0] o_operand_hi,
	output logic [7:0] o_operand_lo,
	output logic [7:0] o_arith_hi,
	output logic [7:0] o_arith_lo,
	output logic o_fetch_uses_config,
	output logic o_fetch_four_words,
	output logic o_fetch_writes_config,
	output logic o_operand_arith_counter,
	output logic o_operand_cfg_fetch,
	output logic o_arith_cfg_op
);

	// ==================================================================
	// Elaboration checks

	// The address register can reach no more than 32 words.
	if (WORDS < 1 ||
		WORDS > config_op_decode_pkg::CFG_WORDS) begin : g_bad_words
		$error("WORDS must lie between 1 and 32.");
	end

	// ==================================================================
	// Functions

	// Full decode of a three-bit half into eight one-hot lines.
	function automatic logic [7:0] half_decode(input logic [2:0] h);
		half_decode = 8'h01 << h;
	endfunction : half_decode

	// Odd parity over the nine data bits of a configuration word.
	function automatic logic odd_parity(input logic [8:0] d);
		odd_parity = ~(^d);
	endfunction : odd_parity

	// Second level: one op line from one line of each first-level group.
	function automatic logic op_line(input logic [7:0] hi, input logic [7:0] lo,
		input logic [5:0] code);
		op_line = hi[code[5:3]] & lo[code[2:0]];
	endfunction : op_line

	// ==================================================================
	// Declarations

	config_op_decode_pkg::mem_state_e state_q;
	config_op_decode_pkg::mem_state_e state_d;
	logic [4:0] config_address_reg_q;
	logic [9:0] config_buffer_reg_q;
	logic [5:0] fetch_stage_opcode_reg_q;
	logic [5:0] operand_stage_opcode_reg_q;
	logic [5:0] arith_stage_opcode_reg_q;
	logic memory_select_ff_q;
	logic [9:0] digit_write_ff_q;
	logic [1:0] word_count_q;
	logic multi_q;
	logic load_q;
	logic [8:0] load_data_q;
	logic word_valid_q;
	logic done_q;
	logic [31:0] rdata_q;
	logic [9:0] cfg_mem [WORDS];
	logic complement_mode_ff;
	logic [9:0] word_line_raw;
	logic [9:0] sensed_word;
	logic [9:0] new_word;
	logic [9:0] read_result;
	logic [9:0] write_pattern;
	logic [31:0] word_select;
	logic [3:0] sel_hi;
	logic [7:0] sel_lo;
	logic is_load_one;
	logic is_load_multi;
	logic is_fetch_one;
	logic is_fetch_multi;
	logic op_cfg_fetch_q;
	logic op_cfg_load_q;
	logic start_ok;
	logic more_words;
	logic [31:0] status_word;
	logic [31:0] decode_word;
	logic [31:0] read_mux;

	// ==================================================================
	// Configuration memory addressing

	// The complement-read flip-flop is abandoned; its output stays zero.
	assign complement_mode_ff = 1'b0;

	// Two-stage selector: a 4-of and an 8-of decode, crossed into 32 lines.
	assign sel_hi = 4'h1 << config_address_reg_q[4:3];
	assign sel_lo = half_decode(config_address_reg_q[2:0]);
	assign word_select = memory_select_ff_q ?
		{sel_hi[3] ? sel_lo : 8'h00, sel_hi[2] ? sel_lo : 8'h00,
		sel_hi[1] ? sel_lo : 8'h00, sel_hi[0] ? sel_lo : 8'h00} :
		32'h0000_0000;

	// Words are only reached through a live word line from the selector.
	assign word_line_raw = word_select[config_address_reg_q] ?
		cfg_mem[config_address_reg_q] : 10'h000;

	// Sense lines cross between arrays, so the upper array reads inverted;
	// address bit five picks the matching strobe polarity.
	assign sensed_word = config_address_reg_q[config_op_decode_pkg::ARRAY_SEL_BIT]
		? ~word_line_raw : word_line_raw;
	assign read_result = complement_mode_ff ? ~sensed_word : sensed_word;

	// A load writes new data with a freshly computed parity bit.
	assign new_word = {odd_parity(load_data_q), load_data_q};

	// The stored pattern keeps the array polarity of the addressed word.
	assign write_pattern = config_address_reg_q[config_op_decode_pkg::ARRAY_SEL_BIT]
		? ~digit_write_ff_q : digit_write_ff_q;

	// ==================================================================
	// Op classes of the fetch, operand and arithmetic stages

	assign is_load_one = fetch_stage_opcode_reg_q == OP_CFG_LOAD_ONE;
	assign is_load_multi = fetch_stage_opcode_reg_q == OP_CFG_LOAD_MULTI;
	assign is_fetch_one = fetch_stage_opcode_reg_q == OP_CFG_FETCH_ONE;
	assign is_fetch_multi = fetch_stage_opcode_reg_q == OP_CFG_FETCH_MULTI;

	// Fetch-stage first and second levels feed the fetch class levels.
	assign o_fetch_hi = half_decode(fetch_stage_opcode_reg_q[5:3]);
	assign o_fetch_lo = half_decode(fetch_stage_opcode_reg_q[2:0]);
	assign o_fetch_uses_config = op_line(o_fetch_hi, o_fetch_lo, OP_CFG_LOAD_ONE)
		| op_line(o_fetch_hi, o_fetch_lo, OP_CFG_LOAD_MULTI)
		| op_line(o_fetch_hi, o_fetch_lo, OP_CFG_FETCH_ONE)
		| op_line(o_fetch_hi, o_fetch_lo, OP_CFG_FETCH_MULTI);
	assign o_fetch_four_words = op_line(o_fetch_hi, o_fetch_lo, OP_CFG_LOAD_MULTI)
		| op_line(o_fetch_hi, o_fetch_lo, OP_CFG_FETCH_MULTI);
	assign o_fetch_writes_config =
		op_line(o_fetch_hi, o_fetch_lo, OP_CFG_LOAD_ONE)
		| op_line(o_fetch_hi, o_fetch_lo, OP_CFG_LOAD_MULTI);

	// Operand-stage levels; no undefined codes reach this stage, so the
	// class map is read without any undefined-code guard.
	assign o_operand_hi = half_decode(operand_stage_opcode_reg_q[5:3]);
	assign o_operand_lo = half_decode(operand_stage_opcode_reg_q[2:0]);
	assign o_operand_arith_counter =
		ARITH_CLASS_MAP[operand_stage_opcode_reg_q];
	assign o_operand_cfg_fetch =
		op_line(o_operand_hi, o_operand_lo, OP_CFG_FETCH_ONE)
		| op_line(o_operand_hi, o_operand_lo, OP_CFG_FETCH_MULTI);

	// Arithmetic-stage levels, used only while the arithmetic counter runs.
	assign o_arith_hi = half_decode(arith_stage_opcode_reg_q[5:3]);
	assign o_arith_lo = half_decode(arith_stage_opcode_reg_q[2:0]);
	assign o_arith_cfg_op = op_line(o_arith_hi, o_arith_lo, OP_CFG_LOAD_ONE)
		| op_line(o_arith_hi, o_arith_lo, OP_CFG_FETCH_ONE);

	// ==================================================================
	// Sequencer control terms

	// A memory cycle only starts for a configuration op outside index jumps.
	assign start_ok = i_cfg_start & o_fetch_uses_config & ~i_index_jump;
	assign more_words = multi_q && (word_count_q != config_op_decode_pkg::LAST_WORD);

	// Next-state logic: read, restoring write, then step or finish.
	always_comb begin
		state_d = state_q;
		case (state_q)
			config_op_decode_pkg::MEM_IDLE: begin
				if (start_ok) begin
					state_d = config_op_decode_pkg::MEM_READ;
				end
			end
			config_op_decode_pkg::MEM_READ: begin
				state_d = config_op_decode_pkg::MEM_WRITE;
			end
			config_op_decode_pkg::MEM_WRITE: begin
				state_d = config_op_decode_pkg::MEM_NEXT;
			end
			config_op_decode_pkg::MEM_NEXT: begin
				state_d = more_words ? config_op_decode_pkg::MEM_READ :
					config_op_decode_pkg::MEM_IDLE;
			end
			default: begin
				state_d = config_op_decode_pkg::MEM_IDLE;
			end
		endcase
	end

	// Sequencer state register.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= config_op_decode_pkg::MEM_IDLE;
		end else if (i_ce) begin
			state_q <= state_d;
		end
	end

	// ==================================================================
	// Configuration address register

	// Loaded with the five instruction bits, stepped between words.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			config_address_reg_q <= config_op_decode_pkg::CFG_ADDR_RESET;
		end else if (i_ce) begin
			if (state_q == config_op_decode_pkg::MEM_NEXT && more_words) begin
				config_address_reg_q <= config_address_reg_q + 5'h01;
			end else if (i_pk12 && state_q == config_op_decode_pkg::MEM_IDLE) begin
				config_address_reg_q <= i_ib_config;
			end
		end
	end

	// During an index jump the address register is the index increment.
	assign o_index_increment = i_index_jump ? config_address_reg_q : 5'h00;

	// ==================================================================
	// Memory strobes, buffer and word count

	// Select and digit-write flip-flops follow the read and write phases.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			memory_select_ff_q <= 1'b0;
			digit_write_ff_q <= config_op_decode_pkg::CFG_WORD_RESET;
		end else if (i_ce) begin
			memory_select_ff_q <= state_d == config_op_decode_pkg::MEM_READ ||
				state_d == config_op_decode_pkg::MEM_WRITE;
			if (state_q == config_op_decode_pkg::MEM_READ) begin
				digit_write_ff_q <= load_q ? new_word : read_result;
			end else begin
				digit_write_ff_q <= config_op_decode_pkg::CFG_WORD_RESET;
			end
		end
	end

	// Buffer takes the sensed word, or the new word when loading.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			config_buffer_reg_q <= config_op_decode_pkg::CFG_WORD_RESET;
		end else if (i_ce && state_q == config_op_decode_pkg::MEM_READ) begin
			config_buffer_reg_q <= load_q ? new_word : read_result;
		end
	end

	// The array: a read pulse leaves the word cleared, a write refills it.
	always_ff @(posedge i_clk) begin
		if (i_ce && memory_select_ff_q) begin
			if (state_q == config_op_decode_pkg::MEM_READ) begin
				cfg_mem[config_address_reg_q] <=
					config_op_decode_pkg::CFG_WORD_RESET;
			end else if (state_q == config_op_decode_pkg::MEM_WRITE) begin
				cfg_mem[config_address_reg_q] <= write_pattern;
			end
		end
	end

	// Operation kind and word count are caught when a sequence starts.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			word_count_q <= 2'h0;
			multi_q <= 1'b0;
			load_q <= 1'b0;
			word_valid_q <= 1'b0;
			done_q <= 1'b0;
		end else if (i_ce) begin
			word_valid_q <= state_q == config_op_decode_pkg::MEM_READ;
			done_q <= state_q == config_op_decode_pkg::MEM_NEXT && !more_words;
			if (state_q == config_op_decode_pkg::MEM_IDLE && start_ok) begin
				word_count_q <= 2'h0;
				multi_q <= o_fetch_four_words;
				load_q <= o_fetch_writes_config;
			end else if (state_q == config_op_decode_pkg::MEM_NEXT) begin
				word_count_q <= word_count_q + 2'h1;
			end
		end
	end

	// Buffer decode into subword form, activity and permutation.
	assign o_subword_form = config_buffer_reg_q[config_op_decode_pkg::FORM_LSB
		+: config_op_decode_pkg::FORM_W];
	assign o_activity = config_buffer_reg_q[config_op_decode_pkg::ACT_LSB
		+: config_op_decode_pkg::ACT_W];
	assign o_permutation = config_buffer_reg_q[config_op_decode_pkg::PERM_LSB
		+: config_op_decode_pkg::PERM_W];
	assign o_parity_error = config_buffer_reg_q[config_op_decode_pkg::PARITY_BIT]
		!= odd_parity(config_buffer_reg_q[config_op_decode_pkg::DATA_W-1:0]);
	assign o_word_valid = word_valid_q;
	assign o_cfg_done = done_q;
	assign o_cfg_busy = state_q != config_op_decode_pkg::MEM_IDLE;
	assign o_memory_select = memory_select_ff_q;
	assign o_digit_write = digit_write_ff_q;

	// ==================================================================
	// Op-code pipeline

	// Three stage registers keep three instructions in flight at once.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fetch_stage_opcode_reg_q <= config_op_decode_pkg::OPCODE_RESET;
			operand_stage_opcode_reg_q <= config_op_decode_pkg::OPCODE_RESET;
			arith_stage_opcode_reg_q <= config_op_decode_pkg::OPCODE_RESET;
		end else if (i_ce) begin
			if (i_pk12) begin
				fetch_stage_opcode_reg_q <= i_ib_opcode;
			end
			if (i_qk_start) begin
				operand_stage_opcode_reg_q <= fetch_stage_opcode_reg_q;
			end
			if (i_pk25 && i_arith_only) begin
				arith_stage_opcode_reg_q <= i_ib_aop_bits;
			end else if (i_qk13 && o_operand_arith_counter) begin
				arith_stage_opcode_reg_q <= operand_stage_opcode_reg_q;
			end
		end
	end

	// Fetch-stage op markers kept for the status word.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			op_cfg_fetch_q <= 1'b0;
			op_cfg_load_q <= 1'b0;
		end else if (i_ce) begin
			op_cfg_fetch_q <= is_fetch_one | is_fetch_multi;
			op_cfg_load_q <= is_load_one | is_load_multi;
		end
	end

	// ==================================================================
	// Register port

	// Load data register feeds every configuration load.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			load_data_q <= 9'h000;
		end else if (i_ce && i_wr && i_addr == config_op_decode_pkg::REG_LOAD_DATA)
		begin
			load_data_q <= i_wdata[config_op_decode_pkg::DATA_W-1:0];
		end
	end

	// Status and decode words show the block's own state.
	assign status_word = {8'h00, op_cfg_load_q, op_cfg_fetch_q, word_count_q,
		state_q, o_cfg_busy, config_address_reg_q, config_buffer_reg_q};
	assign decode_word = {8'h00, arith_stage_opcode_reg_q,
		operand_stage_opcode_reg_q, fetch_stage_opcode_reg_q,
		2'h0, o_operand_arith_counter, o_fetch_writes_config,
		o_fetch_four_words, o_fetch_uses_config};
	assign read_mux = i_addr == config_op_decode_pkg::REG_LOAD_DATA ?
		{23'h000000, load_data_q} :
		i_addr == config_op_decode_pkg::REG_STATUS ? status_word :
		i_addr == config_op_decode_pkg::REG_DECODE ? decode_word : 32'h0000_0000;

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (i_ce) begin
			rdata_q <= i_rd ? read_mux : 32'h0000_0000;
		end
	end

	assign o_rdata = rdata_q;

endmodule : config_memory_op_decode

//--- config_op_decode_pkg.sv
// Constants shared by the configuration memory and op-code decode block.
// Assumes a single 100 MHz clock domain; nothing here holds logic.
package config_op_decode_pkg;

	// ==================================================================
	// Widths and sizes
	localparam int CFG_ADDR_W = 5;
	localparam int CFG_WORDS = 32;
	localparam int CFG_WORD_W = 10;
	localparam int OPCODE_W = 6;
	localparam int HALF_W = 3;
	localparam int GROUP_N = 8;
	localparam int MULTI_WORDS = 4;
	localparam int CNT_W = 2;
	localparam int RADDR_W = 2;
	localparam int RDATA_W = 32;

	// ==================================================================
	// Configuration word fields (bit 9 is the parity bit)
	localparam int PARITY_BIT = 9;
	localparam int FORM_LSB = 7;
	localparam int FORM_W = 2;
	localparam int ACT_LSB = 3;
	localparam int ACT_W = 4;
	localparam int PERM_LSB = 0;
	localparam int PERM_W = 3;
	localparam int DATA_W = 9;
	localparam int ARRAY_SEL_BIT = 4;

	// ==================================================================
	// Register port word indices
	localparam logic [1:0] REG_LOAD_DATA = 2'h0;
	localparam logic [1:0] REG_STATUS = 2'h1;
	localparam logic [1:0] REG_DECODE = 2'h2;

	// Reset values and the last word count.
	localparam logic [CFG_WORD_W-1:0] CFG_WORD_RESET = 10'h000;
	localparam logic [OPCODE_W-1:0] OPCODE_RESET = 6'h00;
	localparam logic [CFG_ADDR_W-1:0] CFG_ADDR_RESET = 5'h00;
	localparam logic [CNT_W-1:0] LAST_WORD = 2'h3;

	// One-hot states of the configuration memory sequencer.
	typedef enum logic [3:0] {
		MEM_IDLE = 4'b0001,
		MEM_READ = 4'b0010,
		MEM_WRITE = 4'b0100,
		MEM_NEXT = 4'b1000
	} mem_state_e;

endpackage : config_op_decode_pkg

//--- config_memory_op_decode_properties.sv
// Port assertions for the configuration memory and op decode block.
// Assumes one clock domain, an active-high reset and default op codes.
`timescale 1ns/1ps
module cfg_op_checker (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic [5:0] i_ib_opcode,
	input wire logic [5:0] i_ib_aop_bits,
	input wire logic i_pk12,
	input wire logic i_pk25,
	input wire logic i_qk_start,
	input wire logic i_qk13,
	input wire logic i_arith_only,
	input wire logic i_index_jump,
	input wire logic i_cfg_start,
	input wire logic [1:0] o_subword_form,
	input wire logic [3:0] o_activity,
	input wire logic [2:0] o_permutation,
	input wire logic o_word_valid,
	input wire logic o_cfg_busy,
	input wire logic o_cfg_done,
	input wire logic o_memory_select,
	input wire logic [9:0] o_digit_write,
	input wire logic [7:0] o_fetch_hi,
	input wire logic [7:0] o_fetch_lo,
	input wire logic [7:0] o_operand_hi,
	input wire logic [7:0] o_operand_lo,
	input wire logic [7:0] o_arith_hi,
	input wire logic [7:0] o_arith_lo,
	input wire logic o_fetch_uses_config,
	input wire logic o_fetch_four_words,
	input wire logic o_fetch_writes_config,
	input wire logic o_operand_arith_counter
);
	// ==================================================================
	// Properties
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// An accepted memory start, and the steps of one word.
	sequence s_start;
		i_ce && i_cfg_start && !o_cfg_busy && o_fetch_uses_config && !i_index_jump;
	endsequence
	sequence s_word;
		o_memory_select && o_cfg_busy ##1 o_word_valid ##1 !o_memory_select;
	endsequence
	property p_fetch;
		i_ce && i_pk12 |=> o_fetch_hi == 8'h01 << ($past(i_ib_opcode) >> 3)
			&& o_fetch_lo == 8'h01 << ($past(i_ib_opcode) & 6'h07);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch decode");
	property p_aop;
		i_ce && i_pk25 && i_arith_only |=> o_arith_hi == 8'h01 <<
			($past(i_ib_aop_bits) >> 3)
			&& o_arith_lo == 8'h01 << ($past(i_ib_aop_bits) & 6'h07);
	endproperty
	a_aop: assert property (p_aop) else $error("direct load");
	property p_qk;
		i_ce && i_qk_start |=> o_operand_hi == $past(o_fetch_hi)
			&& o_operand_lo == $past(o_fetch_lo);
	endproperty
	a_qk: assert property (p_qk) else $error("operand copy");
	property p_arith;
		i_ce && i_qk13 && o_operand_arith_counter && !(i_pk25 && i_arith_only)
			|=> o_arith_hi == $past(o_operand_hi) && o_arith_lo == $past(o_operand_lo);
	endproperty
	a_arith: assert property (p_arith) else $error("arith copy");
	property p_class;
		o_fetch_uses_config == (o_fetch_hi[2] && o_fetch_lo[3:0] != 4'h0)
			&& o_fetch_four_words == (o_fetch_hi[2] && (o_fetch_lo[1] || o_fetch_lo[3]))
			&& o_fetch_writes_config == (o_fetch_hi[2] && o_fetch_lo[1:0] != 2'h0);
	endproperty
	a_class: assert property (p_class) else $error("class level");
	property p_seq;
		s_start |=> s_word;
	endproperty
	a_seq: assert property (p_seq) else $error("word select");
	property p_digits;
		o_word_valid |-> o_digit_write[8:0] ==
			{o_subword_form, o_activity, o_permutation};
	endproperty
	a_digits: assert property (p_digits) else $error("digit write");
	property p_multi;
		s_start ##0 o_fetch_four_words |-> ##12 o_cfg_busy ##1 o_cfg_done && !o_cfg_busy;
	endproperty
	a_multi: assert property (p_multi) else $error("four words");
endmodule : cfg_op_checker

bind config_memory_op_decode cfg_op_checker u_chk (.*);

//--- cycle_control_model.sv
// Instruction buffer and cycle-counter control model.
// Issues one instruction per go pulse; slow mode widens the gaps.
`timescale 1ns/1ps
module cycle_control_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic i_slow,
	input wire logic [5:0] i_op,
	input wire logic [4:0] i_cfg,
	output logic [5:0] o_ib_opcode,
	output logic [4:0] o_ib_config,
	output logic o_pk12,
	output logic o_qk_start,
	output logic o_qk13
);
	logic [3:0] step_q;
	logic [3:0] qk_at;
	// Counter pulses come in order: instruction, operand start, operand 13.
	assign qk_at = i_slow ? 4'h8 : 4'h3;
	assign o_pk12 = step_q == 4'h2;
	assign o_qk_start = step_q == qk_at;
	assign o_qk13 = step_q == qk_at + 4'h1;
	// Fields hold for the instruction, then change every idle cycle.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			step_q <= 4'h0;
			o_ib_opcode <= 6'h00;
			o_ib_config <= 5'h00;
		end else if (i_go) begin
			step_q <= 4'h1;
			o_ib_opcode <= i_op;
			o_ib_config <= i_cfg;
		end else if (step_q != 4'h0) begin
			step_q <= (step_q == qk_at + 4'h2) ? 4'h0 : step_q + 4'h1;
		end else begin
			o_ib_opcode <= ~o_ib_opcode;
			o_ib_config <= ~o_ib_config;
		end
	end
endmodule : cycle_control_model

//--- config_memory_op_decode_tb_top.sv
// Self-checking bench for the configuration memory and op decode block.
// Drives the register port and pulse 25 directly, the other counters through the model.
`timescale 1ns/1ps
module config_memory_op_decode_tb_top;
	logic i_clk, i_rst = 1'b1, i_ce = 1'b1, go = 1'b0, slow = 1'b0;
	logic i_pk12, i_pk25 = 1'b0, i_qk_start, i_qk13, i_arith_only = 1'b0;
	logic i_index_jump = 1'b0, i_cfg_start = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
	logic [4:0] i_ib_config, o_index_increment, cfg = 5'h00;
	logic [5:0] i_ib_opcode, i_ib_aop_bits = 6'h00, op = 6'h00;
	logic [1:0] i_addr = 2'h0, o_subword_form;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic [3:0] o_activity;
	logic [2:0] o_permutation;
	logic o_parity_error, o_word_valid, o_cfg_busy, o_cfg_done;
	logic o_memory_select, o_fetch_uses_config, o_fetch_four_words;
	logic o_fetch_writes_config, o_operand_arith_counter;
	logic o_operand_cfg_fetch, o_arith_cfg_op;
	logic [9:0] o_digit_write;
	logic [7:0] o_fetch_hi, o_fetch_lo, o_operand_hi, o_operand_lo;
	logic [7:0] o_arith_hi, o_arith_lo;
	int failures = 0, total_checks = 0;

	config_memory_op_decode u_dut (.*);
	cycle_control_model u_ctl (.i_clk(i_clk), .i_rst(i_rst), .i_go(go),
		.i_slow(slow), .i_op(op), .i_cfg(cfg), .o_ib_opcode(i_ib_opcode),
		.o_ib_config(i_ib_config), .o_pk12(i_pk12),
		.o_qk_start(i_qk_start), .o_qk13(i_qk13));

	// 100 MHz clock.
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// ==================================================================
	// Tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd
	task automatic run(input logic [5:0] o, input logic [4:0] c);
		@(posedge i_clk);
		op <= o;
		cfg <= c;
		go <= 1'b1;
		@(posedge i_clk);
		go <= 1'b0;
		tick(12);
	endtask : run
	task automatic mem;
		int n;
		@(posedge i_clk);
		i_cfg_start <= 1'b1;
		@(posedge i_clk);
		i_cfg_start <= 1'b0;
		#1;
		for (n = 0; n < 20 && o_cfg_done !== 1'b1; n++) tick(1);
		if (n == 20) begin
			failures++;
			$display("[ERR] %0t memory sequence timed out", $time);
			end_sim();
		end
	endtask : mem
	task automatic word(input logic [4:0] a, input logic [8:0] d);
		wr(2'h0, {23'h0, d});
		run(6'h10, a);
		mem();
		run(6'h12, a);
		mem();
		chk({o_subword_form, o_activity, o_permutation}, d);
		chk(o_parity_error, 0);
		mem();
		chk({o_subword_form, o_activity, o_permutation}, d);
	endtask : word

	// ==================================================================
	// Test sequence
	initial begin
		tick(6);
		i_rst <= 1'b0;
		tick(1);
		chk({o_fetch_hi, o_fetch_lo}, 16'h0101);
		for (int k = 0; k < 5; k++) begin
			run(6'h10 + 6'(k), 5'h00);
			chk({o_fetch_uses_config, o_fetch_four_words, o_fetch_writes_config},
				{k < 4, k == 1 || k == 3, k < 2});
			chk({o_operand_cfg_fetch, o_operand_hi, o_operand_lo},
				{k == 2 || k == 3, 8'h04, 8'h01 << k});
		end
		$display("class test done");
		word(5'h03, 9'h1a5);
		word(5'h13, 9'h05a);
		wr(2'h0, 32'h0000_00f0);
		run(6'h11, 5'h1e);
		mem();
		run(6'h12, 5'h01);
		mem();
		chk({o_subword_form, o_activity, o_permutation}, 9'h0f0);
		$display("memory test done");
		@(posedge i_clk);
		i_index_jump <= 1'b1;
		tick(1);
		chk(o_index_increment, 5'h01);
		@(posedge i_clk);
		i_cfg_start <= 1'b1;
		@(posedge i_clk);
		i_cfg_start <= 1'b0;
		tick(1);
		chk(o_cfg_busy, 0);
		@(posedge i_clk);
		i_index_jump <= 1'b0;
		tick(1);
		chk(o_index_increment, 5'h00);
		$display("index test done");
		run(6'h35, 5'h00);
		chk({o_arith_hi, o_arith_lo}, 16'h4020);
		slow = 1'b1;
		run(6'h07, 5'h00);
		chk({o_fetch_lo, o_arith_hi}, 16'h8040);
		@(posedge i_clk);
		i_ce <= 1'b0;
		i_ib_aop_bits <= 6'h12;
		i_pk25 <= 1'b1;
		i_arith_only <= 1'b1;
		tick(1);
		chk({o_arith_hi, o_arith_lo}, 16'h4020);
		@(posedge i_clk);
		i_ce <= 1'b1;
		@(posedge i_clk);
		i_pk25 <= 1'b0;
		i_arith_only <= 1'b0;
		#1;
		chk({o_arith_cfg_op, o_arith_hi, o_arith_lo},
			{1'b1, 16'h0404});
		$display("pipeline test done");
		rd(2'h2, {8'h0, 6'h12, 6'h07, 6'h07, 6'h0});
		rd(2'h1, 32'h0011_02f0);
		rd(2'h0, 32'h0000_00f0);
		rd(2'h3, 32'h0);
		$display("register test done");
		end_sim();
	end
endmodule : config_memory_op_decode_tb_top
